// File: inc/port_map_pkg.sv
package port_map_pkg;
  // Port address fields
  localparam int addr_w = 2;
  localparam int bank_w = 2;
  localparam int nib_w = 4;
  localparam logic [1:0] bank0 = 2'h0;
  localparam logic [1:0] bank1 = 2'h1;
  localparam logic [1:0] bank2 = 2'h2;
  localparam logic [1:0] port_a_addr = 2'h0;
  localparam logic [1:0] port_b_addr = 2'h1;
  localparam logic [1:0] port_e_addr = 2'h0;
  localparam logic [1:0] port_f_addr = 2'h1;
  localparam logic [1:0] port_l_addr = 2'h2;
  // Direction word location in bank 0 data memory
  localparam logic [6:0] dir_word_addr = 7'h1F;
  localparam logic [3:0] dir_all_in = 4'h0;
  // IF counter input select codes
  localparam logic [1:0] isel_port = 2'h0;
  localparam logic [1:0] isel_am = 2'h1;
  localparam logic [1:0] isel_fm = 2'h2;
  // Pin positions for alternate functions
  localparam int pin_am = 0;
  localparam int pin_fm = 1;
  localparam int pin_si = 2;
  localparam int pin_sck = 3;
  localparam int pin_so = 0;
  // Port operation codes
  typedef enum logic [1:0] {op_out, op_set, op_reset} port_op_t;
endpackage

// File: hdl/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 import port_map_pkg::*; #(
  parameter int width = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Raw and filtered levels
  input wire logic [width-1:0] raw,
  output logic [width-1:0] clean
);
  logic [width-1:0] s1_q;
  logic [width-1:0] s2_q;
  logic [width-1:0] s3_q;
  logic [width-1:0] clean_q;
  wire logic [width-1:0] agree = ~(s2_q ^ s3_q);

  // Refuse a filter with no bits at elaboration
  if (width < 1) begin : g_width_check
    $error("pin_sync3 width must be positive");
  end

  // Three stages; change taken once stages two and three agree
  // Stages rest high, the enabled level of chip enable, so a pin that
  // is already high at release shows no false rising edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      clean_q <= '1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= (agree & s2_q) | (~agree & clean_q);
    end
  end

  assign clean = clean_q;
endmodule

// File: hdl/bank_addressed_bit_direction_port.sv
// Functional notes
// RULE_01 - Port A pins: general bit or alternate input
// RULE_02 - Port B bit 0 doubles as serial out
// RULE_03 - Bank 1 ports 0,1: converter, serial latch
// RULE_04 - Software sets LCD control before port L
// RULE_05 - Direction word 1FH bank 0, bitwise
// RULE_06 - Direction bit 0 input, 1 output
// RULE_07 - Direction kept while word unchanged
// RULE_08 - Power-up, clock stop, CE rise force inputs; a direction word write in the same cycle wins over the force
// RULE_09 - Pins stay inputs until word rewritten
// RULE_10 - Output pin driven from latch bit
// RULE_11 - Output latch undefined at power-up, kept
// RULE_12 - Software writes latch before enabling outputs
// RULE_13 - Set/reset may disturb unmasked bits
// RULE_14 - Pins 0,1 feed IF counter when selected
// RULE_15 - Software selects 00 for plain I/O
// RULE_16 - Software clears bits 3,2 before serial transfer
// RULE_17 - Software deselects IF inputs while CE low
// RULE_18 - Ports selected by bank and address
// RULE_19 - Software returns to bank 0 after ports
// RULE_20 - Port A read: pins if input, latch if output
`timescale 1ns/1ps
module bank_addressed_bit_direction_port import port_map_pkg::*; #(
  parameter int nib = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Power and chip enable events
  input wire logic clock_stop_instruction,
  input wire logic chip_enable_pin,
  // Data memory write snoop
  input wire logic ram_we,
  input wire logic [6:0] ram_addr,
  input wire logic [bank_w-1:0] ram_bank,
  input wire logic [nib-1:0] ram_wdata,
  // Port instruction strobes
  input wire logic port_wr,
  input wire logic [1:0] port_op,
  input wire logic port_rd,
  input wire logic [bank_w-1:0] port_bank,
  input wire logic [addr_w-1:0] port_addr,
  input wire logic [nib-1:0] port_wdata,
  output logic [nib-1:0] port_rdata,
  // IF counter and serial controls
  input wire logic [1:0] input_select_field,
  input wire logic serial_transfer_instruction,
  input wire logic serial_out_bit,
  // Port A pins
  input wire logic [nib-1:0] pa_in,
  output logic [nib-1:0] pa_out,
  output logic [nib-1:0] pa_oe,
  // Port B pins
  output logic [nib-1:0] pb_out,
  // Internal alternate functions
  output logic am_if_count_input,
  output logic fm_if_count_input,
  output logic serial_in,
  output logic serial_clk,
  output logic [nib-1:0] converter_cmp_q,
  output logic [nib-1:0] serial_latch_q,
  output logic [nib-1:0] port_l_q
);
  // Only a four-bit port is served; refuse anything else at elaboration
  if (nib != 4) begin : g_nib_check
    $error("port width must be 4");
  end

  logic [nib-1:0] dir_q;
  logic [nib-1:0] oe_q;
  logic [nib-1:0] latch_q;
  logic [nib-1:0] pb_q;
  logic [nib-1:0] rdata_q;
  logic ce_q;
  logic force_in;
  wire logic [nib-1:0] pa_sync;
  wire logic ce_sync;

  // Pins from outside pass the three-stage filter
  pin_sync3 #(.width(nib + 1)) pin_sync3_inst (
    .mclk(mclk),
    .rstn(rstn),
    .raw({chip_enable_pin, pa_in}),
    .clean({ce_sync, pa_sync})
  );

  // Port selection by bank and direct address
  wire logic sel_a = port_bank == bank0 && port_addr == port_a_addr; // RULE_18
  wire logic sel_b = port_bank == bank0 && port_addr == port_b_addr; // RULE_18
  wire logic sel_e = port_bank == bank1 && port_addr == port_e_addr; // RULE_03
  wire logic sel_f = port_bank == bank1 && port_addr == port_f_addr; // RULE_03
  wire logic sel_l = port_bank == bank2 && port_addr == port_l_addr; // RULE_18
  wire logic dir_we = ram_we && ram_bank == bank0 && ram_addr == dir_word_addr; // RULE_05
  wire logic ce_rise = ce_sync && !ce_q;
  assign force_in = clock_stop_instruction || ce_rise; // RULE_08

  // Full write, or mask set/reset of the current contents
  function automatic logic [3:0] apply_op(input logic [1:0] op, input logic [3:0] cur,
                                          input logic [3:0] wd);
    unique case (op)
      op_set: apply_op = cur | wd;
      op_reset: apply_op = cur & ~wd;
      default: apply_op = wd;
    endcase
  endfunction

  // Set/reset base on port A is the read value, so unselected input pins
  // may load pin levels into the latch; full writes avoid that
  wire logic [nib-1:0] pa_view = (oe_q & latch_q) | (~oe_q & pa_sync); // RULE_20
  wire logic [nib-1:0] latch_d = apply_op(port_op, pa_view, port_wdata); // RULE_13

  // Direction word and pin modes; a forced input leaves the word alone
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dir_q <= dir_all_in;
      oe_q <= dir_all_in; // RULE_08
      ce_q <= 1'b1; // Matches filter rest level: no rise at release
    end else begin
      ce_q <= ce_sync;
      if (dir_we) begin
        dir_q <= ram_wdata; // RULE_05
        oe_q <= ram_wdata; // RULE_06 RULE_09
      end else if (force_in) begin
        oe_q <= dir_all_in; // RULE_09
      end
    end
  end

  // Data latches hold through clock stop; no reset models the undefined
  // power-up content and keeps them across chip-enable events
  always_ff @(posedge mclk) begin
    if (port_wr && sel_a) latch_q <= latch_d; // RULE_11
    if (port_wr && sel_b) pb_q <= apply_op(port_op, pb_q, port_wdata);
    if (port_wr && sel_e) converter_cmp_q <= apply_op(port_op, converter_cmp_q, port_wdata);
    if (port_wr && sel_f) serial_latch_q <= apply_op(port_op, serial_latch_q, port_wdata);
    if (port_wr && sel_l) port_l_q <= apply_op(port_op, port_l_q, port_wdata);
  end

  // Read mux, registered
  wire logic [nib-1:0] rd_mux = sel_a ? pa_view :
                                sel_b ? pb_q :
                                sel_e ? converter_cmp_q :
                                sel_f ? serial_latch_q :
                                sel_l ? port_l_q : '0;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata_q <= '0;
    else if (port_rd) rdata_q <= rd_mux; // RULE_20
  end
  assign port_rdata = rdata_q;

  // Pin drive straight from latch
  assign pa_oe = oe_q; // RULE_07
  assign pa_out = latch_q & oe_q; // RULE_10
  // Serial output overrides port B bit 0 during transfers
  assign pb_out = serial_transfer_instruction ?
                  {pb_q[3:1], serial_out_bit} : pb_q; // RULE_02

  // Alternate inputs gated by input mode; IF counter inputs also by selection
  assign am_if_count_input = !oe_q[pin_am] && input_select_field == isel_am
                             && pa_sync[pin_am]; // RULE_14 RULE_01
  assign fm_if_count_input = !oe_q[pin_fm] && input_select_field == isel_fm
                             && pa_sync[pin_fm]; // RULE_14 RULE_01
  assign serial_in = pa_sync[pin_si] && !oe_q[pin_si]; // RULE_01
  assign serial_clk = pa_sync[pin_sck] && !oe_q[pin_sck]; // RULE_01

  // Checks
  a_force_input: assert property (@(posedge mclk) disable iff (!rstn)
    force_in && !dir_we |=> pa_oe == '0) // RULE_08
    else $error("pins not forced to input");
  a_dir_update: assert property (@(posedge mclk) disable iff (!rstn)
    dir_we |=> pa_oe == $past(ram_wdata)) // RULE_06
    else $error("direction not taken");
  a_dir_hold: assert property (@(posedge mclk) disable iff (!rstn)
    !dir_we && !force_in |=> pa_oe == $past(pa_oe)) // RULE_07
    else $error("direction changed unprompted");
  a_word_kept: assert property (@(posedge mclk) disable iff (!rstn)
    force_in && !dir_we |=> dir_q == $past(dir_q)) // RULE_09
    else $error("direction word cleared");
  a_pin_latch: assert property (@(posedge mclk) disable iff (!rstn)
    ((pa_out ^ latch_q) & pa_oe) == '0) // RULE_10
    else $error("output pin not from latch");
  a_read_view: assert property (@(posedge mclk) disable iff (!rstn)
    port_rd && sel_a |=> port_rdata == $past((pa_oe & pa_out) | (~pa_oe & pa_sync))) // RULE_20
    else $error("port A read wrong");
  a_if_gate: assert property (@(posedge mclk) disable iff (!rstn)
    oe_q[pin_am] |-> !am_if_count_input) // RULE_14
    else $error("IF input while output");
  a_so_bit: assert property (@(posedge mclk) disable iff (!rstn)
    serial_transfer_instruction |-> pb_out[pin_so] == serial_out_bit) // RULE_02
    else $error("serial out not on pin");
  a_full_write: assert property (@(posedge mclk) disable iff (!rstn)
    port_wr && sel_a && port_op == op_out |=> latch_q == $past(port_wdata)) // RULE_13
    else $error("full write lost");
  c_dir_write: cover property (@(posedge mclk) disable iff (!rstn) dir_we);
  c_ce_rise: cover property (@(posedge mclk) disable iff (!rstn) ce_rise && |oe_q);
  c_read_a: cover property (@(posedge mclk) disable iff (!rstn) port_rd && sel_a);
endmodule

// File: verif/pin_board.sv
`timescale 1ns/1ps
// Board circuitry on the port A pins
module pin_board (
  // Port side
  input wire logic [3:0] pa_out,
  input wire logic [3:0] pa_oe,
  // Board source level
  input wire logic [3:0] ext_drv,
  // Resolved pins
  output logic [3:0] pa_in
);
  // Port wins where it drives; board source elsewhere, so no pin floats
  assign pa_in = (pa_out & pa_oe) | (ext_drv & ~pa_oe);
endmodule

// File: verif/bank_addressed_bit_direction_port_tb.sv
`timescale 1ns/1ps
module bank_addressed_bit_direction_port_tb;
  import port_map_pkg::*;
  logic mclk = 0, rstn = 0, cstop = 0, ce = 1, ram_we = 0, port_wr = 0, port_rd = 0;
  logic ser_go = 0, so_bit = 0, am, fm, si, ser_clk;
  logic [6:0] ram_addr = 7'h00;
  logic [1:0] ram_bank = 2'h0, port_op = 2'h0, port_bank = 2'h0, port_addr = 2'h0, isel = 2'h0;
  logic [3:0] ram_wdata = 4'h0, port_wdata = 4'h0, ext = 4'h0, rdata, pa_in, pa_out, pa_oe;
  logic [3:0] pb_out, cmp, sl, pl;
  int miscompares = 0, n_checks = 0;
  bank_addressed_bit_direction_port bank_addressed_bit_direction_port_inst (
    .mclk(mclk), .rstn(rstn), .clock_stop_instruction(cstop), .chip_enable_pin(ce),
    .ram_we(ram_we), .ram_addr(ram_addr), .ram_bank(ram_bank), .ram_wdata(ram_wdata),
    .port_wr(port_wr), .port_op(port_op), .port_rd(port_rd), .port_bank(port_bank),
    .port_addr(port_addr), .port_wdata(port_wdata), .port_rdata(rdata),
    .input_select_field(isel), .serial_transfer_instruction(ser_go),
    .serial_out_bit(so_bit), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out),
    .am_if_count_input(am), .fm_if_count_input(fm), .serial_in(si), .serial_clk(ser_clk),
    .converter_cmp_q(cmp), .serial_latch_q(sl), .port_l_q(pl));
  pin_board pin_board_inst (.pa_out(pa_out), .pa_oe(pa_oe), .ext_drv(ext), .pa_in(pa_in));
  // Free-running 250 MHz clock
  always #2 mclk = ~mclk;
  // Inputs move 1 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Leading tick keeps a strobe's fall and next rise in different steps
  task automatic dir_wr(input logic [1:0] bank, input logic [3:0] d);
    tick(1);
    ram_we = 1;
    ram_bank = bank;
    ram_addr = dir_word_addr;
    ram_wdata = d;
    tick(1);
    ram_we = 0;
  endtask
  task automatic pwr(input logic [1:0] bank, input logic [1:0] a, input port_op_t op,
                     input logic [3:0] d);
    tick(1);
    port_wr = 1;
    port_bank = bank;
    port_addr = a;
    port_op = op;
    port_wdata = d;
    tick(1);
    port_wr = 0;
  endtask
  task automatic prd(input logic [1:0] bank, input logic [1:0] a);
    tick(1);
    port_rd = 1;
    port_bank = bank;
    port_addr = a;
    tick(1);
    port_rd = 0;
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence; pin filter settles within 5 cycles
  initial begin
    tick(12);
    rstn = 1;
    tick(6);
    check("oe_reset", pa_oe, dir_all_in);
    pwr(bank0, port_a_addr, op_out, 4'h5);
    dir_wr(bank0, 4'h4);
    check("oe_bit2", pa_oe, 4'h4);
    check("out_bit2", pa_out, 4'h4);
    dir_wr(bank1, 4'hF);
    check("oe_other_bank", pa_oe, 4'h4);
    dir_wr(bank0, 4'hF);
    check("oe_all", pa_oe, 4'hF);
    pwr(bank0, port_a_addr, op_set, 4'hA);
    check("out_set", pa_out, 4'hF);
    pwr(bank0, port_a_addr, op_reset, 4'h3);
    check("out_reset", pa_out, 4'hC);
    dir_wr(bank0, 4'hC);
    ext = 4'h1;
    tick(5);
    prd(bank0, port_a_addr);
    check("read_mix", rdata, 4'hD);
    check("out_kept", pa_out, 4'hC);
    cstop = 1;
    tick(1);
    cstop = 0;
    check("oe_stop", pa_oe, 4'h0);
    tick(8);
    check("oe_stays_in", pa_oe, 4'h0);
    dir_wr(bank0, 4'hC);
    check("latch_held", pa_out, 4'hC);
    ce = 0;
    tick(6);
    ce = 1;
    tick(6);
    check("oe_ce_rise", pa_oe, 4'h0);
    dir_wr(bank0, 4'h0);
    isel = isel_am;
    tick(5);
    check("am_in", {3'h0, am}, 4'h1);
    isel = isel_fm;
    ext = 4'h2;
    tick(5);
    check("fm_in", {3'h0, fm}, 4'h1);
    isel = isel_port;
    ext = 4'h4;
    ser_go = 1;
    so_bit = 1;
    tick(5);
    check("ser_in", {3'h0, si}, 4'h1);
    ext = 4'hC;
    tick(5);
    check("ser_clk", {3'h0, ser_clk}, 4'h1);
    pwr(bank0, port_b_addr, op_out, 4'hA);
    check("pb_ser", pb_out, 4'hB);
    ser_go = 0;
    tick(1);
    check("pb_plain", pb_out, 4'hA);
    pwr(bank1, port_e_addr, op_out, 4'h6);
    pwr(bank1, port_f_addr, op_out, 4'h9);
    pwr(bank2, port_l_addr, op_out, 4'h3);
    check("cmp", cmp, 4'h6);
    check("ser_latch", sl, 4'h9);
    check("port_l", pl, 4'h3);
    prd(bank1, 2'h3);
    check("unmapped", rdata, 4'h0);
    pwr(bank0, port_a_addr, op_out, 4'h1);
    dir_wr(bank0, 4'h1);
    isel = isel_am;
    tick(5);
    check("out_bit0", pa_out, 4'h1);
    check("am_gated", {3'h0, am}, 4'h0);
    isel = isel_port;
    close_out();
  end
endmodule
